// ===== dv/sscu_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module sscu_host_model
  import sscu_pkg::*;
(
  // clock and bit period
  input  wire logic        i_core_clk,
  input  wire logic [15:0] i_div,
  // line
  input  wire logic        i_txd,
  output logic             o_rxd
);
  initial o_rxd = 1'b1;

  // ****************************************
  // transmit: start, 8 data lsb first, one stop, no terminator bytes
  // ****************************************
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] fr;
    fr = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge i_core_clk);
      o_rxd <= fr[i];
      repeat (i_div - 1) @(posedge i_core_clk);
    end
  endtask

  // stop bit low for three quarters of a bit, so the receiver, idle again from mid-stop,
  // takes a false start that the half-bit start check drops when the line is back high
  task automatic send_bad_stop(input logic [7:0] b);
    logic [8:0] fr;
    fr = {b, 1'b0};
    for (int i = 0; i < 9; i++) begin
      @(posedge i_core_clk);
      o_rxd <= fr[i];
      repeat (i_div - 1) @(posedge i_core_clk);
    end
    @(posedge i_core_clk);
    o_rxd <= 1'b0;
    repeat (3 * i_div / 4) @(posedge i_core_clk);
    o_rxd <= 1'b1;
    repeat (2 * i_div) @(posedge i_core_clk);
  endtask

  // ****************************************
  // receive one answer byte, giving up after 14 bit times
  // ****************************************
  task automatic recv_byte(output logic [7:0] b, output bit ok);
    int n;
    ok = 1'b0;
    b  = 8'h00;
    n  = 0;
    while (i_txd !== 1'b0 && n < 14 * i_div) begin
      @(posedge i_core_clk);
      n++;
    end
    if (i_txd === 1'b0) begin
      // sample mid-bit, stop bit must be high
      repeat (i_div / 2) @(posedge i_core_clk);
      for (int i = 0; i < 8; i++) begin
        repeat (i_div) @(posedge i_core_clk);
        b[i] = i_txd;
      end
      repeat (i_div) @(posedge i_core_clk);
      ok = (i_txd === 1'b1);
    end
  endtask
endmodule
`default_nettype wire

// ===== dv/sscu_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
module sscu_top_bench;
  import sscu_pkg::*;

  logic               clk;
  logic               rst_b;
  logic               rxd;
  logic               txd;
  logic [3:0]         addr;
  logic [31:0]        wdata;
  logic               wr;
  logic               rd;
  logic [31:0]        rdata;
  sscu_fault_t        fault;
  logic signed [15:0] ambient;
  logic               key;
  logic               ascii;
  logic               save_en;
  logic               laser;
  logic               lamp;
  logic [7:0]         err_code;
  sscu_ind_t          ind;
  logic               irq;
  logic [15:0]        host_div;
  int                 errors;
  int                 cmp_count;
  int                 cyc;
  logic [31:0]        d;
  logic [7:0]         ans;
  bit                 ok;
  logic [9:0]         fv [0:10] = '{10'h200, 10'h100, 10'h080, 10'h040, 10'h020, 10'h010,
                                    10'h008, 10'h004, 10'h002, 10'h001, 10'h120};
  logic [7:0]         fe [0:10] = '{8'h10, 8'h0C, 8'h08, 8'h04, 8'h80, 8'h60,
                                    8'h40, 8'h20, 8'h02, 8'h00, 8'h8C};
  logic [3:0]         fi [0:10] = '{4'h0, 4'h0, 4'h2, 4'h1, 4'h0, 4'h0,
                                    4'h0, 4'h0, 4'h8, 4'h4, 4'h0};

  sscu_top u_dut (
    .i_core_clk(clk), .i_rst_b(rst_b), .i_rxd(rxd), .o_txd(txd),
    .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd),
    .o_reg_rdata(rdata), .i_fault(fault), .i_ambient_dc(ambient),
    .i_key_laser_toggle(key), .o_ascii_mode(ascii), .o_nvm_save_en(save_en),
    .o_laser_en(laser), .o_laser_lamp(lamp), .o_err_code(err_code), .o_ind(ind),
    .o_irq(irq)
  );

  sscu_host_model u_host (.i_core_clk(clk), .i_div(host_div), .i_txd(txd), .o_rxd(rxd));

  // ****************************************
  // clock, reset, timeout
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // serial part needs about 85k cycles at the fastest rate
  always @(posedge clk) begin
    cyc++;
    if (cyc == 100000) begin
      errors++;
      report_and_stop();
    end
  end

  // ****************************************
  // helpers
  // ****************************************
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t ns: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic reg_wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  task automatic reg_rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    v = rdata;
  endtask

  // the answer begins inside the last stop bit, so listen while sending it
  task automatic cmd(input logic [7:0] c, input logic [7:0] a, input bit has_arg);
    logic [7:0] last;
    last = has_arg ? a : c;
    if (has_arg)
      u_host.send_byte(c);
    fork
      u_host.send_byte(last);
      u_host.recv_byte(ans, ok);
    join
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    rst_b = 1'b0; addr = 4'h0; wdata = 32'h0; wr = 1'b0; rd = 1'b0;
    fault = '0; ambient = 16'sh00C8; key = 1'b0; host_div = 16'(CLK_HZ / BAUD_115K2);
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    tick(1);
    chk(ascii, 1'b0);
    chk(save_en, 1'b1);
    chk({laser, lamp, txd}, 3'h1);
    reg_rd(REG_CTRL, d); chk(d, 32'h0);
    reg_rd(REG_STATUS, d); chk(d, 32'h2);
    reg_rd(4'hF, d); chk(d, 32'h0);
    reg_wr(REG_CTRL, 32'h4);
    reg_wr(REG_CTRL, 32'h5);
    reg_rd(REG_CTRL, d); chk(d, 32'h4);
    // serial commands at the fastest rate
    cmd(CMD_PROTO, ARG_ONE, 1); chk({ok, ans}, 9'h101);
    chk(ascii, 1'b1);
    cmd(CMD_SAVE, ARG_ONE, 1); chk({ok, ans}, 9'h101);
    chk(save_en, 1'b0);
    cmd(CMD_SAVE_POLL, 8'h00, 0); chk({ok, ans}, 9'h101);
    cmd(8'h55, 8'h00, 0); chk(ok, 1'b0);
    cmd(CMD_PROTO, 8'h02, 1); chk({ok, ans}, 9'h101);
    chk({ascii, save_en, laser}, 3'h4);
    cmd(CMD_SAVE, ARG_ZERO, 1); chk({ok, ans}, 9'h100);
    chk(save_en, 1'b1);
    cmd(CMD_PROTO, ARG_ZERO, 1); chk({ok, ans}, 9'h100);
    chk(ascii, 1'b0);
    // error digits and indications, single faults then a pair
    for (int i = 0; i < 11; i++) begin
      @(posedge clk);
      fault <= sscu_fault_t'(fv[i]);
      tick(3);
      chk(err_code, fe[i]);
      chk(ind, fi[i]);
    end
    reg_rd(REG_ERR, d); chk(d, 32'h08C);
    // laser by host, cut by ambient, toggled by key
    reg_wr(REG_CTRL, 32'hC);
    tick(2); chk({laser, lamp}, 2'h3);
    @(posedge clk); ambient <= 16'sd501;
    tick(3); chk({laser, lamp}, 2'h0);
    @(posedge clk); ambient <= 16'sd500;
    tick(3); chk({laser, lamp}, 2'h3);
    @(posedge clk); key <= 1'b1;
    @(posedge clk); key <= 1'b0;
    tick(2); chk({laser, lamp}, 2'h0);
    // interrupt: raise, mask, clear
    reg_rd(REG_IRQ_STAT, d); chk(d, 32'hF);
    reg_wr(REG_IRQ_EN, 32'h8);
    tick(2); chk(irq, 1'b1);
    reg_wr(REG_IRQ_EN, 32'h0);
    tick(2); chk(irq, 1'b0);
    reg_wr(REG_IRQ_EN, 32'h8);
    reg_wr(REG_IRQ_CLR, 32'hF);
    reg_rd(REG_IRQ_STAT, d); chk(d, 32'h0);
    chk(irq, 1'b0);
    // a frame with a low stop bit is dropped and flagged, not decoded
    u_host.send_bad_stop(CMD_PROTO);
    reg_rd(REG_IRQ_STAT, d); chk(d, 32'h10);
    chk(ascii, 1'b0);
    report_and_stop();
  end
endmodule
`default_nettype wire

// ===== hdl/sscu_pkg.sv
package sscu_pkg;

  // ****************************************
  // clock and serial framing
  // ****************************************
  localparam int unsigned CLK_HZ        = 50_000_000;
  localparam int unsigned DATA_BITS     = 8;
  localparam int unsigned STOP_BITS     = 1;
  localparam int unsigned BAUD_9K6      = 9_600;
  localparam int unsigned BAUD_19K2     = 19_200;
  localparam int unsigned BAUD_38K4     = 38_400;
  localparam int unsigned BAUD_57K6     = 57_600;
  localparam int unsigned BAUD_115K2    = 115_200;
  localparam int unsigned DIV_W         = 16;

  // ****************************************
  // command codes and arguments
  // ****************************************
  localparam logic [7:0] CMD_PROTO      = 8'h83;
  localparam logic [7:0] CMD_SAVE       = 8'h70;
  localparam logic [7:0] CMD_SAVE_POLL  = 8'h71;
  localparam logic [7:0] ARG_ZERO       = 8'h00;
  localparam logic [7:0] ARG_ONE        = 8'h01;

  // ****************************************
  // rate selection
  // ****************************************
  localparam logic [2:0] RATE_9K6       = 3'h0;
  localparam logic [2:0] RATE_19K2      = 3'h1;
  localparam logic [2:0] RATE_38K4      = 3'h2;
  localparam logic [2:0] RATE_57K6      = 3'h3;
  localparam logic [2:0] RATE_115K2     = 3'h4;
  localparam logic [2:0] RATE_DEFAULT   = RATE_9K6;

  // ****************************************
  // error digit codes
  // ****************************************
  localparam logic [3:0] D1_OK          = 4'h0;
  localparam logic [3:0] D1_HEAD_SHORT  = 4'h1;
  localparam logic [3:0] D1_BOX_COLD    = 4'h2;
  localparam logic [3:0] D1_BOX_HOT     = 4'h4;
  localparam logic [3:0] D1_BOX_OPEN    = 4'h6;
  localparam logic [3:0] D1_BOX_SHORT   = 4'h8;
  localparam logic [3:0] D2_OK          = 4'h0;
  localparam logic [3:0] D2_OBJ_HOT     = 4'h2;
  localparam logic [3:0] D2_HEAD_COLD   = 4'h4;
  localparam logic [3:0] D2_HEAD_HOT    = 4'h8;
  localparam logic [3:0] D2_HEAD_OPEN   = 4'hC;

  // ambient limit in tenths of a degree, signed
  localparam logic signed [15:0] LASER_CUTOFF_DC = 16'sd500;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic head_probe_short;
    logic head_probe_open;
    logic head_hot;
    logic head_cold;
    logic box_probe_short;
    logic box_probe_open;
    logic box_hot;
    logic box_cold;
    logic obj_hot;
    logic obj_cold;
  } sscu_fault_t;

  typedef struct packed {
    logic obj_too_hot_indication;
    logic obj_too_cold_indication;
    logic head_too_hot_indication;
    logic head_too_cold_indication;
  } sscu_ind_t;

  // interrupt status bit positions
  localparam int unsigned EV_PROTO      = 0;
  localparam int unsigned EV_SAVE       = 1;
  localparam int unsigned EV_UNKNOWN    = 2;
  localparam int unsigned EV_LASER_CUT  = 3;
  localparam int unsigned EV_FRAME_ERR  = 4;
  localparam int unsigned EV_W          = 5;

  // register offsets
  localparam logic [3:0] REG_CTRL       = 4'h0;
  localparam logic [3:0] REG_STATUS     = 4'h1;
  localparam logic [3:0] REG_IRQ_STAT   = 4'h2;
  localparam logic [3:0] REG_IRQ_EN     = 4'h3;
  localparam logic [3:0] REG_IRQ_CLR    = 4'h4;
  localparam logic [3:0] REG_ERR        = 4'h5;
  localparam int unsigned CTRL_RATE_LSB = 0;
  localparam int unsigned CTRL_LASER    = 3;

  function automatic logic [DIV_W-1:0] baud_div(input logic [2:0] rate);
    int unsigned b;
    unique case (rate)
      RATE_19K2:  b = BAUD_19K2;
      RATE_38K4:  b = BAUD_38K4;
      RATE_57K6:  b = BAUD_57K6;
      RATE_115K2: b = BAUD_115K2;
      default:    b = BAUD_9K6;
    endcase
    return DIV_W'(CLK_HZ / b);
  endfunction

endpackage

// ===== hdl/sscu_top.sv
`timescale 1ns/1ps
`default_nettype none
module sscu_top
  import sscu_pkg::*;
(
  // clock and reset
  input  wire logic               i_core_clk,
  input  wire logic               i_rst_b,
  // serial line
  input  wire logic               i_rxd,
  output logic                    o_txd,
  // register port
  input  wire logic [3:0]         i_reg_addr,
  input  wire logic [31:0]        i_reg_wdata,
  input  wire logic               i_reg_wr,
  input  wire logic               i_reg_rd,
  output logic [31:0]             o_reg_rdata,
  // sensor state
  input  wire sscu_fault_t        i_fault,
  input  wire logic signed [15:0] i_ambient_dc,
  input  wire logic               i_key_laser_toggle,
  // outputs
  output logic                    o_ascii_mode,
  output logic                    o_nvm_save_en,
  output logic                    o_laser_en,
  output logic                    o_laser_lamp,
  output logic [7:0]              o_err_code,
  output sscu_ind_t               o_ind,
  output logic                    o_irq
);

  // ****************************************
  // serial engine
  // ****************************************
  logic [2:0]       rate_q, rate_d;
  logic [7:0]       rx_data, tx_data_q, tx_data_d;
  logic             rx_valid, rx_err, tx_ready, tx_valid_q, tx_valid_d;

  sscu_uart u_uart (
    .i_core_clk (i_core_clk),
    .i_rst_b    (i_rst_b),
    .i_div      (baud_div(rate_q)),
    .i_rxd      (i_rxd),
    .o_txd      (o_txd),
    .o_rx_data  (rx_data),
    .o_rx_valid (rx_valid),
    .o_rx_err   (rx_err),
    .i_tx_data  (tx_data_q),
    .i_tx_valid (tx_valid_q),
    .o_tx_ready (tx_ready)
  );

  // ****************************************
  // command interpreter
  // ****************************************
  typedef enum logic [1:0] {CI_CMD, CI_ARG} sscu_ci_st_t;
  sscu_ci_st_t ci_st_q, ci_st_d;
  logic [7:0]  cmd_q, cmd_d;
  logic        ascii_q, ascii_d, save_q, save_d, laser_req_q, laser_req_d;
  logic [EV_W-1:0] ev;

  // a fresh answer overwrites a pending one; host must wait for each answer
  always_comb begin
    ci_st_d     = ci_st_q;
    cmd_d       = cmd_q;
    ascii_d     = ascii_q;
    save_d      = save_q;
    tx_data_d   = tx_data_q;
    tx_valid_d  = tx_valid_q && !tx_ready;
    ev          = '0;
    ev[EV_FRAME_ERR] = rx_err;
    if (rx_valid) begin
      unique case (ci_st_q)
        CI_CMD: begin
          cmd_d = rx_data;
          if (rx_data == CMD_PROTO || rx_data == CMD_SAVE) begin
            ci_st_d = CI_ARG;
          end else if (rx_data == CMD_SAVE_POLL) begin
            tx_data_d  = save_q ? ARG_ZERO : ARG_ONE;
            tx_valid_d = 1'b1;
          end else begin
            ev[EV_UNKNOWN] = 1'b1;
          end
        end
        CI_ARG: begin
          ci_st_d = CI_CMD;
          if (cmd_q == CMD_PROTO) begin
            if (rx_data == ARG_ZERO || rx_data == ARG_ONE) begin
              ascii_d = (rx_data == ARG_ONE);
            end
            tx_data_d      = {7'h00, ascii_d};
            ev[EV_PROTO]   = 1'b1;
          end else begin
            if (rx_data == ARG_ZERO || rx_data == ARG_ONE) begin
              save_d = (rx_data == ARG_ZERO);
            end
            tx_data_d    = save_d ? ARG_ZERO : ARG_ONE;
            ev[EV_SAVE]  = 1'b1;
          end
          tx_valid_d = 1'b1;
        end
      endcase
    end
  end

  // ****************************************
  // laser with ambient cutoff
  // ****************************************
  logic ambient_hot, laser_on_q, laser_on_d;
  assign ambient_hot = i_ambient_dc > LASER_CUTOFF_DC;

  // ****************************************
  // registers
  // ****************************************
  logic [EV_W-1:0] irq_stat_q, irq_stat_d, irq_en_q, irq_en_d;
  logic [31:0]     rdata_q, rdata_d;
  logic            wr_ctrl;
  logic [EV_W-1:0] ev_all;

  assign wr_ctrl = i_reg_wr && i_reg_addr == REG_CTRL;

  always_comb begin
    rate_d      = rate_q;
    laser_req_d = laser_req_q;
    irq_en_d    = irq_en_q;
    if (i_key_laser_toggle) begin
      laser_req_d = !laser_req_q;
    end
    if (wr_ctrl) begin
      if (i_reg_wdata[CTRL_RATE_LSB +: 3] <= RATE_115K2) begin
        rate_d = i_reg_wdata[CTRL_RATE_LSB +: 3];
      end
      laser_req_d = i_reg_wdata[CTRL_LASER];
    end
    if (i_reg_wr && i_reg_addr == REG_IRQ_EN) begin
      irq_en_d = i_reg_wdata[EV_W-1:0];
    end
    laser_on_d = laser_req_d && !ambient_hot;
    ev_all = ev;
    ev_all[EV_LASER_CUT] = ambient_hot && laser_req_q && laser_on_q;
    // a new event wins over a clear in the same cycle
    irq_stat_d = irq_stat_q;
    if (i_reg_wr && i_reg_addr == REG_IRQ_CLR) begin
      irq_stat_d = irq_stat_q & ~i_reg_wdata[EV_W-1:0];
    end
    irq_stat_d = irq_stat_d | ev_all;
    rdata_d = '0;
    if (i_reg_rd) begin
      unique case (i_reg_addr)
        REG_CTRL:     rdata_d = {28'h0, laser_req_q, rate_q};
        REG_STATUS:   rdata_d = {28'h0, ambient_hot, laser_on_q, save_q, ascii_q};
        REG_IRQ_STAT: rdata_d = {27'h0, irq_stat_q};
        REG_IRQ_EN:   rdata_d = {27'h0, irq_en_q};
        REG_ERR:      rdata_d = {20'h0, o_ind, o_err_code};
        default:      rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ci_st_q     <= CI_CMD;
      cmd_q       <= '0;
      ascii_q     <= 1'b0;
      save_q      <= 1'b1;
      tx_data_q   <= '0;
      tx_valid_q  <= 1'b0;
      rate_q      <= RATE_DEFAULT;
      laser_req_q <= 1'b0;
      laser_on_q  <= 1'b0;
      irq_stat_q  <= '0;
      irq_en_q    <= '0;
      rdata_q     <= '0;
    end else begin
      ci_st_q     <= ci_st_d;
      cmd_q       <= cmd_d;
      ascii_q     <= ascii_d;
      save_q      <= save_d;
      tx_data_q   <= tx_data_d;
      tx_valid_q  <= tx_valid_d;
      rate_q      <= rate_d;
      laser_req_q <= laser_req_d;
      laser_on_q  <= laser_on_d;
      irq_stat_q  <= irq_stat_d;
      irq_en_q    <= irq_en_d;
      rdata_q     <= rdata_d;
    end
  end

  // ****************************************
  // error digits and indications
  // ****************************************
  logic [3:0] dig1, dig2;
  always_comb begin
    dig1 = D1_OK;
    if (i_fault.box_probe_short)       dig1 = D1_BOX_SHORT;
    else if (i_fault.box_probe_open)   dig1 = D1_BOX_OPEN;
    else if (i_fault.box_hot)          dig1 = D1_BOX_HOT;
    else if (i_fault.box_cold)         dig1 = D1_BOX_COLD;
    else if (i_fault.head_probe_short) dig1 = D1_HEAD_SHORT;
    dig2 = D2_OK;
    if (i_fault.head_probe_open)       dig2 = D2_HEAD_OPEN;
    else if (i_fault.head_hot)         dig2 = D2_HEAD_HOT;
    else if (i_fault.head_cold)        dig2 = D2_HEAD_COLD;
    else if (i_fault.obj_hot)          dig2 = D2_OBJ_HOT;
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_err_code <= '0;
      o_ind      <= '0;
    end else begin
      o_err_code <= {dig1, dig2};
      o_ind      <= '{i_fault.obj_hot, i_fault.obj_cold,
                      i_fault.head_hot, i_fault.head_cold};
    end
  end

  // volatile-only when saving off: the store logic watches this level
  assign o_nvm_save_en = save_q;
  assign o_ascii_mode  = ascii_q;
  assign o_laser_en    = laser_on_q;
  assign o_laser_lamp  = laser_on_q;
  assign o_reg_rdata   = rdata_q;
  assign o_irq         = |(irq_stat_q & irq_en_q);

  // ****************************************
  // checks
  // ****************************************
  a_laser_cutoff: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_b)
    ambient_hot |=> !o_laser_en)
    else $error("laser on while ambient too hot");

  a_lamp_follows: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_b)
    o_laser_lamp == o_laser_en)
    else $error("lamp differs from laser");

  a_key_toggle: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_b)
    (i_key_laser_toggle && !wr_ctrl) |=> laser_req_q != $past(laser_req_q))
    else $error("key did not toggle laser request");

  a_poll_answer: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_b)
    (rx_valid && ci_st_q == CI_CMD && rx_data == CMD_SAVE_POLL)
      |=> tx_valid_q && tx_data_q == (save_q ? ARG_ZERO : ARG_ONE))
    else $error("poll answer wrong");

  a_proto_set: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_b)
    (rx_valid && ci_st_q == CI_ARG && cmd_q == CMD_PROTO && rx_data == ARG_ONE)
      |=> o_ascii_mode && tx_valid_q)
    else $error("protocol select failed");

  a_save_set: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_b)
    (rx_valid && ci_st_q == CI_ARG && cmd_q == CMD_SAVE && rx_data == ARG_ONE)
      |=> !o_nvm_save_en)
    else $error("save disable failed");

  a_unknown_keep: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_b)
    (ev[EV_UNKNOWN]) |=> $stable(ascii_q) && $stable(save_q))
    else $error("unknown command changed mode");

  a_err_hot_box: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_b)
    (i_fault.box_hot && !i_fault.box_probe_short && !i_fault.box_probe_open)
      |=> o_err_code[7:4] == D1_BOX_HOT)
    else $error("box hot digit wrong");

  a_err_head_open: assert property (
    @(posedge i_core_clk) disable iff (!i_rst_b)
    i_fault.head_probe_open |=> o_err_code[3:0] == D2_HEAD_OPEN)
    else $error("head open digit wrong");

endmodule
`default_nettype wire

// ===== hdl/sscu_uart.sv
`timescale 1ns/1ps
`default_nettype none
module sscu_uart
  import sscu_pkg::*;
(
  // clock and reset
  input  wire logic              i_core_clk,
  input  wire logic              i_rst_b,
  // bit period
  input  wire logic [DIV_W-1:0]  i_div,
  // line
  input  wire logic              i_rxd,
  output logic                   o_txd,
  // receive
  output logic [7:0]             o_rx_data,
  output logic                   o_rx_valid,
  output logic                   o_rx_err,
  // transmit
  input  wire logic [7:0]        i_tx_data,
  input  wire logic              i_tx_valid,
  output logic                   o_tx_ready
);

  // ****************************************
  // receiver: 8 data, no parity, 1 stop
  // ****************************************
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} sscu_rx_st_t;
  sscu_rx_st_t      rx_st_q, rx_st_d;
  logic [DIV_W-1:0] rx_cnt_q, rx_cnt_d;
  logic [3:0]       rx_bit_q, rx_bit_d;
  logic [7:0]       rx_sh_q, rx_sh_d, rx_dat_q, rx_dat_d;
  logic             rx_v_q, rx_v_d, rx_e_q, rx_e_d;

  always_comb begin
    rx_st_d  = rx_st_q;
    rx_cnt_d = rx_cnt_q - 1'b1;
    rx_bit_d = rx_bit_q;
    rx_sh_d  = rx_sh_q;
    rx_dat_d = rx_dat_q;
    rx_v_d   = 1'b0;
    rx_e_d   = 1'b0;
    unique case (rx_st_q)
      RX_IDLE: begin
        rx_cnt_d = {1'b0, i_div[DIV_W-1:1]};
        if (!i_rxd) begin
          rx_st_d = RX_START;
        end
      end
      RX_START: if (rx_cnt_q == '0) begin
        // load one less: the cycle at zero is the last one of the bit
        rx_cnt_d = i_div - 1'b1;
        rx_bit_d = '0;
        rx_st_d  = i_rxd ? RX_IDLE : RX_DATA;
      end
      RX_DATA: if (rx_cnt_q == '0) begin
        rx_cnt_d = i_div - 1'b1;
        rx_sh_d  = {i_rxd, rx_sh_q[7:1]};
        rx_bit_d = rx_bit_q + 1'b1;
        if (rx_bit_q == 4'(DATA_BITS - 1)) begin
          rx_st_d = RX_STOP;
        end
      end
      RX_STOP: if (rx_cnt_q == '0) begin
        rx_st_d = RX_IDLE;
        if (i_rxd) begin
          rx_dat_d = rx_sh_q;
          rx_v_d   = 1'b1;
        end else begin
          rx_e_d = 1'b1;
        end
      end
    endcase
  end

  // ****************************************
  // transmitter
  // ****************************************
  logic [DIV_W-1:0] tx_cnt_q, tx_cnt_d;
  logic [3:0]       tx_bit_q, tx_bit_d;
  logic [9:0]       tx_sh_q, tx_sh_d;
  logic             tx_busy_q, tx_busy_d;

  assign o_tx_ready = !tx_busy_q;

  always_comb begin
    tx_cnt_d  = tx_cnt_q;
    tx_bit_d  = tx_bit_q;
    tx_sh_d   = tx_sh_q;
    tx_busy_d = tx_busy_q;
    if (!tx_busy_q) begin
      if (i_tx_valid) begin
        tx_sh_d   = {1'b1, i_tx_data, 1'b0};
        tx_cnt_d  = i_div - 1'b1;
        tx_bit_d  = 4'(DATA_BITS + STOP_BITS + 1);
        tx_busy_d = 1'b1;
      end
    end else if (tx_cnt_q == '0) begin
      tx_cnt_d = i_div - 1'b1;
      tx_sh_d  = {1'b1, tx_sh_q[9:1]};
      tx_bit_d = tx_bit_q - 1'b1;
      if (tx_bit_q == 4'h1) begin
        tx_busy_d = 1'b0;
      end
    end else begin
      tx_cnt_d = tx_cnt_q - 1'b1;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rx_st_q   <= RX_IDLE;
      rx_cnt_q  <= '0;
      rx_bit_q  <= '0;
      rx_sh_q   <= '0;
      rx_dat_q  <= '0;
      rx_v_q    <= 1'b0;
      rx_e_q    <= 1'b0;
      tx_cnt_q  <= '0;
      tx_bit_q  <= '0;
      tx_sh_q   <= '1;
      tx_busy_q <= 1'b0;
    end else begin
      rx_st_q   <= rx_st_d;
      rx_cnt_q  <= rx_cnt_d;
      rx_bit_q  <= rx_bit_d;
      rx_sh_q   <= rx_sh_d;
      rx_dat_q  <= rx_dat_d;
      rx_v_q    <= rx_v_d;
      rx_e_q    <= rx_e_d;
      tx_cnt_q  <= tx_cnt_d;
      tx_bit_q  <= tx_bit_d;
      tx_sh_q   <= tx_sh_d;
      tx_busy_q <= tx_busy_d;
    end
  end

  assign o_txd      = tx_busy_q ? tx_sh_q[0] : 1'b1;
  assign o_rx_data  = rx_dat_q;
  assign o_rx_valid = rx_v_q;
  assign o_rx_err   = rx_e_q;

endmodule
`default_nettype wire
